/* File: hdl/i2w_pkg.sv */
// i2w_pkg: constants and types of the command-driven i2c master write path
// assumes a 40 MHz system clock and software that fills commands and tx ram first

package i2w_pkg;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int SCL_HALF_NS   = 500;
	// least time, so round up
	localparam int SCL_HALF_CYC  = (SCL_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// --------------------------------------------------------------
	// command codes and ram
	// --------------------------------------------------------------
	localparam logic [2:0] CMD_WRITE   = 3'h1;
	localparam logic [2:0] CMD_STOP    = 3'h2;
	localparam logic [2:0] CMD_READ    = 3'h3;
	localparam logic [2:0] CMD_END     = 3'h4;
	localparam logic [2:0] CMD_RESTART = 3'h6;
	localparam int         RAM_AW      = 4;
	localparam int         RAM_DEPTH   = 16;
	localparam int         CMD_SLOTS   = 8;
	localparam logic [2:0] SYNC_RST    = 3'h7;

	typedef struct packed {
		logic [2:0] command_code;
		logic       ack_value;
		logic       ack_exp;
		logic       ack_check_en;
		logic [7:0] byte_num;
	} i2w_cmd_s;

	typedef struct packed {
		logic              en;
		logic              direct;
		logic [RAM_AW-1:0] addr;
		logic [7:0]        data;
	} i2w_ramwr_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_FETCH = 3'b010,
		ST_START = 3'b011,
		ST_BIT   = 3'b100,
		ST_ACK   = 3'b101,
		ST_STOP  = 3'b110
	} i2w_state_e;

endpackage

/* File: hdl/i2w_master_write.sv */
// i2w_master_write: command list driven i2c master, write path only
// assumes open-drain pads outside; scl and sda come in asynchronous
`timescale 1ns/10ps
`default_nettype none

module i2w_master_write
	import i2w_pkg::*;
#(
	parameter int DEPTH = RAM_DEPTH,
	parameter int NCMD  = CMD_SLOTS
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	input  wire logic                  master_mode_select,
	input  wire logic                  transfer_start_trigger,
	input  wire i2w_cmd_s [NCMD-1:0]   cmd_list,
	input  wire i2w_ramwr_s            ram_wr,
	input  wire logic                  scl_i,
	output logic                       scl_o,
	output logic                       scl_oe,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe,
	output logic                       busy,
	output logic                       transfer_done_event,
	output logic                       ack_mismatch_event
);

	localparam int AW = $clog2(DEPTH);
	localparam int IW = $clog2(NCMD);

	// half-period timer is eight bits wide, so longer halves cannot be counted
	if (DEPTH < 2 || DEPTH > RAM_DEPTH || NCMD < 2 || SCL_HALF_CYC < 4 ||
		SCL_HALF_CYC > 256) begin : g_chk
		$error("i2w_master_write: unsupported parameter values");
	end

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	i2w_state_e    st_q, st_d;
	logic [1:0]    ph_q, ph_d;
	logic [7:0]    tmr_q;
	logic [IW-1:0] idx_q, idx_d;
	logic [7:0]    cnt_q, cnt_d;
	logic [2:0]    bit_q, bit_d;
	logic [7:0]    tx_q, tx_d;
	logic [AW-1:0] rd_q, rd_d, wr_q;
	logic          abort_q, abort_d;
	logic          scl_low_q, scl_low_d, sda_low_q, sda_low_d;
	logic          done_q, done_d, nack_q, nack_d, ld_tmr;
	logic [2:0]    scl_s_q, sda_s_q;
	logic          scl_hi_q, sda_hi_q;
	logic [7:0]    ram_q [DEPTH];

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	i2w_cmd_s      cur;
	wire           tick      = (tmr_q == 8'h00);
	wire           start_go  = transfer_start_trigger & master_mode_select;
	wire           last_cmd  = (idx_q == IW'(NCMD - 1));
	wire           ack_eval  = (st_q == ST_ACK) && (ph_q == 2'h1) && tick;
	wire           ack_bad   = cur.ack_check_en && (sda_hi_q != cur.ack_exp);
	wire           stop_end  = (st_q == ST_STOP) && (ph_q == 2'h2) && tick;
	wire [AW-1:0]  wr_addr   = ram_wr.direct ? ram_wr.addr[AW-1:0] : wr_q;
	wire           fifo_wr   = ram_wr.en & ~ram_wr.direct;
	wire [7:0]     ram_rd    = ram_q[rd_q];
	assign cur = cmd_list[idx_q];

	assign scl_o  = 1'b0;
	assign sda_o  = 1'b0;
	assign scl_oe = scl_low_q;
	assign sda_oe = sda_low_q;
	assign busy   = (st_q != ST_IDLE);
	assign transfer_done_event = done_q;
	assign ack_mismatch_event  = nack_q;

	// --------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		bit_d = bit_q;
		tx_d = tx_q;
		rd_d = rd_q;
		abort_d = abort_q;
		done_d = 1'b0;
		nack_d = 1'b0;
		ld_tmr = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (start_go) begin
					st_d = ST_WAIT;
					idx_d = '0;
					rd_d = '0;
					abort_d = 1'b0;
				end
			end
			ST_WAIT: begin
				if (scl_hi_q) begin
					st_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				ld_tmr = 1'b1;
				ph_d = 2'h0;
				case (cur.command_code)
					CMD_RESTART: begin
						st_d = ST_START;
					end
					CMD_WRITE: begin
						st_d = ST_BIT;
						cnt_d = cur.byte_num;
						bit_d = 3'h7;
						tx_d = ram_rd;
						rd_d = ptr_inc(rd_q);
					end
					// read and end are not served here; close the bus instead
					default: begin
						st_d = ST_STOP;
					end
				endcase
			end
			ST_START: begin
				if (tick) begin
					ld_tmr = 1'b1;
					ph_d = ph_q + 2'h1;
					if (ph_q == 2'h3) begin
						st_d = last_cmd ? ST_STOP : ST_FETCH;
						idx_d = last_cmd ? idx_q : idx_q + 1'b1;
					end
				end
			end
			ST_BIT: begin
				if (tick) begin
					ld_tmr = 1'b1;
					ph_d = ph_q ^ 2'h1;
					if (ph_q == 2'h1) begin
						bit_d = bit_q - 3'h1;
						tx_d = {tx_q[6:0], 1'b0};
						if (bit_q == 3'h0) begin
							st_d = ST_ACK;
						end
					end
				end
			end
			ST_ACK: begin
				if (tick) begin
					ld_tmr = 1'b1;
					ph_d = ph_q ^ 2'h1;
					if (ph_q == 2'h1) begin
						if (ack_bad) begin
							nack_d = 1'b1;
							abort_d = 1'b1;
							st_d = ST_STOP;
						end else if (cnt_q == 8'h01) begin
							st_d = last_cmd ? ST_STOP : ST_FETCH;
							idx_d = last_cmd ? idx_q : idx_q + 1'b1;
						end else begin
							st_d = ST_BIT;
							cnt_d = cnt_q - 8'h01;
							bit_d = 3'h7;
							tx_d = ram_rd;
							rd_d = ptr_inc(rd_q);
						end
					end
				end
			end
			ST_STOP: begin
				if (tick) begin
					ld_tmr = 1'b1;
					ph_d = ph_q + 2'h1;
					if (ph_q == 2'h2) begin
						st_d = ST_IDLE;
						ph_d = 2'h0;
						done_d = ~abort_q && (cur.command_code == CMD_STOP);
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------
	// line drive; in data and ack slots sda only moves once scl is already held low
	// --------------------------------------------------------------
	always_comb begin
		scl_low_d = 1'b0;
		sda_low_d = 1'b0;
		case (st_q)
			ST_FETCH: begin
				scl_low_d = scl_low_q;
				sda_low_d = sda_low_q;
			end
			ST_START: begin
				scl_low_d = (ph_q == 2'h0) || (ph_q == 2'h3);
				sda_low_d = ph_q[1];
			end
			ST_BIT: begin
				scl_low_d = (ph_q == 2'h0);
				sda_low_d = scl_low_q ? ~tx_q[7] : sda_low_q;
			end
			ST_ACK: begin
				scl_low_d = (ph_q == 2'h0);
				sda_low_d = scl_low_q ? 1'b0 : sda_low_q;
			end
			ST_STOP: begin
				scl_low_d = (ph_q == 2'h0);
				sda_low_d = (ph_q != 2'h2) && (scl_low_q || sda_low_q);
			end
			default: begin
				scl_low_d = 1'b0;
			end
		endcase
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (clk_en && ram_wr.en) begin
			ram_q[wr_addr] <= ram_wr.data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_s_q <= SYNC_RST;
			sda_s_q <= SYNC_RST;
			scl_hi_q <= 1'b1;
			sda_hi_q <= 1'b1;
		end else if (clk_en) begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			if (scl_s_q[1] == scl_s_q[2]) scl_hi_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2]) sda_hi_q <= sda_s_q[2];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			ph_q <= 2'h0;
			tmr_q <= 8'h00;
			idx_q <= '0;
			cnt_q <= 8'h00;
			bit_q <= 3'h0;
			tx_q <= 8'h00;
			rd_q <= '0;
			wr_q <= '0;
			abort_q <= 1'b0;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			ph_q <= ph_d;
			tmr_q <= ld_tmr ? 8'(SCL_HALF_CYC - 1) : (tick ? tmr_q : tmr_q - 8'h01);
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			rd_q <= rd_d;
			// fifo write pointer rewinds once the stop is out, unless a fifo write lands in that cycle
			wr_q <= fifo_wr ? ptr_inc(wr_q) : (stop_end ? '0 : wr_q);
			abort_q <= abort_d;
			scl_low_q <= scl_low_d;
			sda_low_q <= sda_low_d;
			done_q <= done_d;
			nack_q <= nack_d;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk iff clk_en);
	endclocking
	default disable iff (sys_rst);

	sequence s_bus_free;
		!scl_oe && !sda_oe;
	endsequence

	property p_wait_high;
		(st_q == ST_WAIT && st_d == ST_FETCH) |-> scl_hi_q;
	endproperty
	a_wait_high: assert property (p_wait_high) else $error("left wait with scl low");

	property p_start_only;
		($rose(sda_oe) && !scl_oe) |-> (st_q == ST_START);
	endproperty
	a_start_only: assert property (p_start_only) else $error("sda fell under high scl");

	property p_load;
		(st_q == ST_FETCH && cur.command_code == CMD_WRITE) |=> (tx_q == $past(ram_rd));
	endproperty
	a_load: assert property (p_load) else $error("first byte not from ram");

	property p_done;
		transfer_done_event |-> (($past(st_q) == ST_STOP) and s_bus_free);
	endproperty
	a_done: assert property (p_done) else $error("done without stop");

	property p_mismatch;
		(ack_eval && cur.ack_check_en && sda_hi_q != cur.ack_exp)
			|=> ack_mismatch_event && st_q == ST_STOP ##1 !ack_mismatch_event;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("missed ack mismatch");

	property p_nocheck;
		(ack_eval && !cur.ack_check_en) |=> !ack_mismatch_event && !abort_q;
	endproperty
	a_nocheck: assert property (p_nocheck) else $error("unchecked ack aborted");

	property p_nack_stop;
		ack_mismatch_event |-> ##[1:200] (st_q == ST_STOP && ph_q == 2'h2 && !scl_oe && sda_oe);
	endproperty
	a_nack_stop: assert property (p_nack_stop) else $error("no stop after mismatch");

	property p_wrap;
		(((st_q == ST_FETCH && cur.command_code == CMD_WRITE) ||
			(ack_eval && !ack_bad && cnt_q != 8'h01)) && rd_q == AW'(DEPTH - 1))
			|=> (rd_q == '0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("ram pointer did not wrap");

	property p_count;
		(st_q == ST_BIT) |-> (cnt_q != 8'h00);
	endproperty
	a_count: assert property (p_count) else $error("byte count zero");

	property p_idle;
		stop_end |=> ((st_q == ST_IDLE) and s_bus_free);
	endproperty
	a_idle: assert property (p_idle) else $error("not idle after stop");

endmodule

`default_nettype wire

/* File: tb/i2w_slave_model.sv */
// i2w_slave_model: behavioural i2c slave that logs every byte it hears
// assumes wired-and lines built by the bench with pull-ups
`timescale 1ns/10ps
`default_nettype none

module i2w_slave_model (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic nack,
	output logic      ack_oe
);
	logic [7:0] sh;
	logic [7:0] mem [0:63];
	int         bit_n;
	int         n_rx;
	int         n_start;
	int         n_stop;

	initial begin
		ack_oe = 1'b0;
		bit_n = 0;
		n_rx = 0;
		n_start = 0;
		n_stop = 0;
	end

	// start and stop are sda edges while scl is high
	always @(negedge sda) if (scl) begin
		bit_n = 0;
		n_start++;
	end
	always @(posedge sda) if (scl) n_stop++;

	// every address is taken as ours; no compare, so any byte gets logged
	always @(posedge scl) begin
		if (bit_n < 8) begin
			sh = {sh[6:0], sda};
			bit_n++;
			if (bit_n == 8) begin
				mem[n_rx % 64] = sh;
				n_rx++;
			end
		end else begin
			bit_n = 0;
		end
	end
	// pull sda for the ack slot only; released lines float up
	always @(negedge scl) ack_oe <= (bit_n == 8) && !nack;
endmodule

`default_nettype wire

/* File: tb/tb_i2w_master_write.sv */
// tb_i2w_master_write: random and corner write sequences against a slave model
// assumes default ram depth and command slots of the package
`timescale 1ns/10ps
`default_nettype none

module tb_i2w_master_write;
	import i2w_pkg::*;
	// ----------------------------------------------------------
	// signals
	// ----------------------------------------------------------
	logic                     clk, sys_rst, mms, trig, hold, nack;
	i2w_cmd_s [CMD_SLOTS-1:0] cmds;
	i2w_ramwr_s               ramw;
	logic                     scl_oe, sda_oe, busy, done_ev, mis_ev, ack_oe;
	logic [7:0]               img [0:RAM_DEPTH-1];
	logic [9:0]               a10;
	int                       error_cnt, n_tests, seed, n_done, n_mis, n;
	wire logic scl = !(scl_oe | hold);
	wire logic sda = !(sda_oe | ack_oe);

	i2w_master_write u_dut (
		.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .master_mode_select(mms),
		.transfer_start_trigger(trig), .cmd_list(cmds), .ram_wr(ramw),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.busy(busy), .transfer_done_event(done_ev), .ack_mismatch_event(mis_ev)
	);
	i2w_slave_model u_slv (.scl(scl), .sda(sda), .nack(nack), .ack_oe(ack_oe));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (done_ev === 1'b1) n_done++;
		if (mis_ev === 1'b1) n_mis++;
	end
	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] exp_byte(int i);
		return img[i % RAM_DEPTH];
	endfunction
	task automatic load(int cnt, logic dir);
		for (int i = 0; i < cnt; i++) begin
			@(negedge clk);
			ramw = '{en: 1'b1, direct: dir, addr: i[RAM_AW-1:0], data: img[i]};
		end
		@(negedge clk);
		ramw.en = 1'b0;
	endtask
	task automatic pulse();
		@(negedge clk);
		trig = 1'b1;
		@(negedge clk);
		trig = 1'b0;
	endtask
	task automatic run(int nb, logic ce, logic ax, int rx, logic ok, logic hd);
		int t;
		int b_rx;
		int b_st;
		int b_sp;
		b_rx = u_slv.n_rx;
		b_st = u_slv.n_start;
		b_sp = u_slv.n_stop;
		n_done = 0;
		n_mis = 0;
		t = 0;
		cmds[1] = '{CMD_WRITE, 1'b0, ax, ce, nb[7:0]};
		hold = hd;
		// held scl must get through the synchroniser before the trigger
		if (hd) repeat (4) @(negedge clk);
		pulse();
		if (hd) begin
			repeat (100) @(negedge clk);
			chk("idle lines while scl low", 1, {scl_oe, sda_oe, busy});
			pulse();
			hold = 1'b0;
		end
		while (busy !== 1'b0 && t < 20000) begin
			@(negedge clk);
			t++;
		end
		chk("timeout", 0, t == 20000);
		repeat (3) @(negedge clk);
		chk("done", ok, n_done);
		chk("mismatch", !ok, n_mis);
		chk("starts", 1, u_slv.n_start - b_st);
		chk("stops", 1, u_slv.n_stop - b_sp);
		chk("bytes", rx, u_slv.n_rx - b_rx);
		for (int i = 0; i < rx; i++) chk("byte", exp_byte(i), u_slv.mem[(b_rx + i) % 64]);
		chk("released", 0, {scl_oe, sda_oe});
	endtask
	task automatic fill(int cnt);
		for (int i = 1; i < cnt; i++) img[i] = 8'($random(seed));
		img[0] = {7'($random(seed)), 1'b0};
	endtask
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		seed = 32'h094D;
		{sys_rst, mms, trig, hold, nack} = 5'h10;
		cmds = '0;
		ramw = '0;
		cmds[0] = '{CMD_RESTART, 1'b0, 1'b0, 1'b0, 8'h00};
		cmds[2] = '{CMD_STOP, 1'b0, 1'b0, 1'b0, 8'h00};
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		chk("after reset", 0, {scl_oe, sda_oe, busy, done_ev, mis_ev});
		pulse();
		repeat (5) @(negedge clk);
		chk("refused without master mode", 0, busy);
		mms = 1'b1;
		fill(1);
		load(1, 1'b1);
		run(1, 1'b1, 1'b0, 1, 1'b1, 1'b1);
		for (int k = 0; k < 3; k++) begin
			n = 1 + ($unsigned($random(seed)) % RAM_DEPTH);
			fill(n);
			load(n, 1'b1);
			run(n, 1'b1, 1'b0, n, 1'b1, 1'b0);
		end
		nack = 1'b1;
		run(n, 1'b1, 1'b0, 1, 1'b0, 1'b0);
		run(n, 1'b1, 1'b1, n, 1'b1, 1'b0);
		run(n, 1'b0, 1'b0, n, 1'b1, 1'b0);
		nack = 1'b0;
		a10 = 10'($random(seed));
		fill(6);
		img[0] = {7'h78 | {5'h00, a10[9:8]}, 1'b0};
		img[1] = a10[7:0];
		load(6, 1'b1);
		run(6, 1'b1, 1'b0, 6, 1'b1, 1'b0);
		fill(5);
		load(5, 1'b1);
		run(5, 1'b1, 1'b0, 5, 1'b1, 1'b0);
		fill(RAM_DEPTH);
		load(RAM_DEPTH, 1'b0);
		run(RAM_DEPTH + 2, 1'b1, 1'b0, RAM_DEPTH + 2, 1'b1, 1'b0);
		// an end command closes the bus but is no completed transfer
		cmds[2].command_code = CMD_END;
		n_done = 0;
		pulse();
		while (busy !== 1'b0) @(negedge clk);
		repeat (3) @(negedge clk);
		chk("done after end", 0, n_done);
		chk("released after end", 0, {scl_oe, sda_oe});
		test_done();
	end
	initial begin
		repeat (95000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule

`default_nettype wire
